/* ecf_params.svh */
/*
 * constants of the electronic cam follower: register offsets, field limits,
 * reset values and table geometry.
 * assumes it is included by bare name from the package and the design file.
 */
`ifndef ECF_PARAMS_SVH
`define ECF_PARAMS_SVH

// ==========================================================================
// geometry
`define ECF_AXES 8
`define ECF_POS_W 32
`define ECF_ADDR_W 8
`define ECF_INTERVALS 256
`define ECF_POINTS 257
`define ECF_CYCLE_MAX 32'h007fffff
`define ECF_CHANGE_MAX 32'h7fffffff

// ==========================================================================
// single registers (byte addresses)
`define ECF_OFS_ENABLE 8'h00
`define ECF_OFS_MASTER 8'h04
`define ECF_OFS_CYCLE 8'h08
`define ECF_OFS_WIDTH 8'h0c
`define ECF_OFS_START 8'h10
`define ECF_OFS_INDEX 8'h14
`define ECF_OFS_MPOS 8'h18
`define ECF_OFS_TPTR 8'h1c

// per-axis groups: address[7:5] picks the group, address[4:2] the axis
`define ECF_GRP_CHANGE 3'h1
`define ECF_GRP_ENGAGE 3'h2
`define ECF_GRP_DISENGAGE 3'h3
`define ECF_GRP_TABLE 3'h4
`define ECF_GRP_TARGET 3'h5
`define ECF_GRP_STATUS 3'h6

// reset values
`define ECF_RST_WIDTH 32'h00000001
`define ECF_RST_ZERO 32'h00000000

`endif

/* ecf_pkg.sv */
/*
 * types of the electronic cam follower.
 * assumes ecf_params.svh is on the include path.
 */
package ecf_pkg;
`include "ecf_params.svh"

    // ======================================================================
    // cam mode of the whole engine
    typedef enum logic {
        ECF_CAM_OFF = 1'b0,
        ECF_CAM_ON = 1'b1
    } ecf_cam_type;

    // follower state of one axis
    typedef enum logic [1:0] {
        ECF_AX_IDLE = 2'b00,
        ECF_AX_WAIT = 2'b01,
        ECF_AX_FOLLOW = 2'b10
    } ecf_axis_type;

endpackage : ecf_pkg

/* ecf_cam_follower.sv */
/*
 * electronic cam follower: wraps the master main-encoder position modulo a
 * programmed cycle and drives table-interpolated targets to up to seven
 * follower axes, with per-axis engage and disengage points.
 * assumes encoder counts and the register port live on the same clock; the
 * servo loops take slave_target and load it on slave_redefine.
 */
// Local design decisions: the register offsets and strobed register access.
// ==========================================================================
// How it works
// - up to seven followers track one master
// - master taken only from main encoder inputs
// - master select picks exactly one axis
// - master position kept within one cycle
// - cycle end redefines master and slaves zero
// - cycle and slave change writes are limited
// - uniform table intervals, at most 256 of them
// - interval setup holds width and start
// - table points zero to 256, one per axis
// - enable write one enters, zero leaves cam
// - slave engages when master equals engage point
// - engage point beyond cycle engages at once
// - engagement redefines slave modulo slave cycle
// - slave disengages at its disengage point
// - disengage point beyond cycle stops at once
// - current table index writable and readable
// - cam enable state readable by host
`timescale 1ns/1ps
`default_nettype none
`include "ecf_params.svh"

module ecf_cam_follower
    import ecf_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // register port
    input wire logic [`ECF_ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    // main encoder counts, axis a in bits 32a+31..32a
    input wire logic [`ECF_AXES*32-1:0] main_enc_pos,
    // follower outputs
    output logic [`ECF_AXES*32-1:0] slave_target,
    output logic [`ECF_AXES-1:0] slave_following,
    output logic [`ECF_AXES-1:0] slave_redefine,
    output logic master_redefine
);

    // ======================================================================
    // storage
    logic [31:0] table_mem [0:`ECF_POINTS*`ECF_AXES-1];
    logic [31:0] change_reg [0:`ECF_AXES-1];
    logic [31:0] engage_reg [0:`ECF_AXES-1];
    logic [31:0] disengage_reg [0:`ECF_AXES-1];
    logic [31:0] target_reg [0:`ECF_AXES-1];
    ecf_axis_type axis_reg [0:`ECF_AXES-1];
    logic [`ECF_AXES-1:0] disarm_reg;
    ecf_cam_type cam_reg;
    logic [2:0] master_reg;
    logic [31:0] cycle_reg, width_reg, start_reg, base_reg, mpos_reg;
    logic [8:0] index_reg, tptr_reg;
    logic [2:0] rr_reg;
    logic wrap_reg;
    logic [`ECF_AXES-1:0] redef_reg;

    // unsigned restoring division, shared by index and interpolation
    function automatic logic [63:0] ecf_udiv(input logic [63:0] num, input logic [31:0] den);
        logic [63:0] q;
        logic [32:0] r;
        q = '0;
        r = '0;
        if (den != 32'h0) begin
            for (int i = 63; i >= 0; i--) begin
                r = {r[31:0], num[i]};
                if (r >= {1'b0, den}) begin
                    r = r - {1'b0, den};
                    q[i] = 1'b1;
                end
            end
        end
        return q;
    endfunction : ecf_udiv

    // ======================================================================
    // decode
    wire logic [2:0] grp = reg_addr[7:5];
    wire logic [2:0] wax = reg_addr[4:2];
    wire logic cam_on = (cam_reg == ECF_CAM_ON);

    // master from the selected main encoder only; no auxiliary path exists
    wire logic [31:0] enc_master = main_enc_pos[32*master_reg +: 32];
    wire logic signed [31:0] rel_m = enc_master - base_reg;

    // table index from wrapped position, truncated
    logic signed [31:0] rel_t;
    logic [63:0] quo;
    logic [63:0] qw;
    logic [8:0] idx_calc;
    logic [31:0] frac;
    always_comb begin
        rel_t = mpos_reg - start_reg;
        quo = ecf_udiv({32'h0, rel_t}, width_reg);
        qw = quo[31:0] * width_reg;
        if (rel_t < 0) begin
            idx_calc = 9'h0;
            frac = 32'h0;
        end else if (quo >= 64'(`ECF_INTERVALS)) begin
            idx_calc = 9'(`ECF_INTERVALS - 1);
            frac = width_reg;
        end else begin
            idx_calc = quo[8:0];
            frac = rel_t - qw[31:0];
        end
    end

    // interpolation for the axis under round-robin service
    logic signed [31:0] pt_a, pt_b, t_raw, t_wrap, chg;
    logic signed [32:0] diff;
    logic [32:0] mag;
    logic [63:0] prod, step;
    always_comb begin
        pt_a = table_mem[{index_reg, rr_reg}];
        pt_b = table_mem[{index_reg + 9'h1, rr_reg}];
        diff = 33'(pt_b) - 33'(pt_a);
        mag = diff[32] ? 33'(-diff) : 33'(diff);
        prod = 64'(mag) * 64'(frac);
        step = ecf_udiv(prod, width_reg);
        t_raw = diff[32] ? pt_a - step[31:0] : pt_a + step[31:0];
        chg = change_reg[rr_reg];
        // fold into one slave cycle; change is held as a magnitude
        t_wrap = t_raw;
        if (chg != 0 && t_raw >= chg) begin
            t_wrap = t_raw - chg;
        end else if (chg != 0 && t_raw < 0) begin
            t_wrap = t_raw + chg;
        end
    end

    // ======================================================================
    // configuration writes; cycle and change are clipped to their limits
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            master_reg <= 3'h0;
            cycle_reg <= `ECF_RST_ZERO;
            width_reg <= `ECF_RST_WIDTH;
            start_reg <= `ECF_RST_ZERO;
            tptr_reg <= 9'h0;
        end else if (reg_write && grp == 3'h0) begin
            unique case (reg_addr)
                // master choice only while cam is off, so one master per cycle
                `ECF_OFS_MASTER: if (!cam_on) master_reg <= reg_wdata[2:0];
                `ECF_OFS_CYCLE: cycle_reg <= (reg_wdata > `ECF_CYCLE_MAX) ?
                    `ECF_CYCLE_MAX : reg_wdata;
                `ECF_OFS_WIDTH: width_reg <= reg_wdata;
                `ECF_OFS_START: start_reg <= reg_wdata;
                `ECF_OFS_TPTR: tptr_reg <= reg_wdata[8:0];
                default: ;
            endcase
        end
    end

    // per-axis tables; pointer beyond 256 is ignored
    always_ff @(posedge clock) begin
        if (reg_write && grp == `ECF_GRP_TABLE && tptr_reg < 9'(`ECF_POINTS)) begin
            table_mem[{tptr_reg, wax}] <= reg_wdata;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            for (int a = 0; a < `ECF_AXES; a++) begin
                change_reg[a] <= `ECF_RST_ZERO;
                engage_reg[a] <= `ECF_RST_ZERO;
                disengage_reg[a] <= `ECF_RST_ZERO;
            end
        end else if (reg_write) begin
            if (grp == `ECF_GRP_CHANGE) begin
                change_reg[wax] <= reg_wdata[31] ? `ECF_CHANGE_MAX : reg_wdata;
            end
            if (grp == `ECF_GRP_ENGAGE) begin
                engage_reg[wax] <= reg_wdata;
            end
            if (grp == `ECF_GRP_DISENGAGE) begin
                disengage_reg[wax] <= reg_wdata;
            end
        end
    end

    // ======================================================================
    // cam mode
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cam_reg <= ECF_CAM_OFF;
        end else if (reg_write && reg_addr == `ECF_OFS_ENABLE) begin
            cam_reg <= reg_wdata[0] ? ECF_CAM_ON : ECF_CAM_OFF;
        end
    end

    // master wrap; a fresh enable starts the cycle at the present count
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            base_reg <= 32'h0;
            mpos_reg <= 32'h0;
            wrap_reg <= 1'b0;
        end else begin
            wrap_reg <= 1'b0;
            if (!cam_on) begin
                base_reg <= enc_master;
                mpos_reg <= 32'h0;
            end else if (cycle_reg != 0 && rel_m >= $signed(cycle_reg)) begin
                base_reg <= base_reg + cycle_reg;
                mpos_reg <= rel_m - cycle_reg;
                wrap_reg <= 1'b1;
            end else if (cycle_reg != 0 && rel_m < 0) begin
                base_reg <= base_reg - cycle_reg;
                mpos_reg <= rel_m + cycle_reg;
            end else begin
                mpos_reg <= rel_m;
            end
        end
    end

    // index: host write wins over tracking in the same cycle
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            index_reg <= 9'h0;
        end else if (reg_write && reg_addr == `ECF_OFS_INDEX) begin
            index_reg <= (reg_wdata[8:0] > 9'(`ECF_INTERVALS - 1)) ?
                9'(`ECF_INTERVALS - 1) : reg_wdata[8:0];
        end else if (cam_on) begin
            index_reg <= idx_calc;
        end
    end

    // ======================================================================
    // follower states; the master axis itself never follows
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            for (int a = 0; a < `ECF_AXES; a++) begin
                axis_reg[a] <= ECF_AX_IDLE;
            end
            disarm_reg <= '0;
            redef_reg <= '0;
        end else begin
            for (int a = 0; a < `ECF_AXES; a++) begin
                redef_reg[a] <= 1'b0;
                unique case (axis_reg[a])
                    ECF_AX_IDLE: ;
                    ECF_AX_WAIT: begin
                        if (cam_on && 3'(a) != master_reg && (engage_reg[a] >= cycle_reg ||
                                mpos_reg == engage_reg[a])) begin
                            axis_reg[a] <= ECF_AX_FOLLOW;
                            redef_reg[a] <= 1'b1;
                        end
                    end
                    ECF_AX_FOLLOW: begin
                        if (!cam_on || 3'(a) == master_reg) begin
                            axis_reg[a] <= ECF_AX_IDLE;
                        end else if (disarm_reg[a] && (disengage_reg[a] >= cycle_reg ||
                                mpos_reg == disengage_reg[a])) begin
                            axis_reg[a] <= ECF_AX_IDLE;
                            disarm_reg[a] <= 1'b0;
                        end else if (wrap_reg) begin
                            redef_reg[a] <= 1'b1;
                        end
                    end
                    default: axis_reg[a] <= ECF_AX_IDLE;
                endcase
                // an arming write beats the hardware clear of the same cycle
                if (reg_write && grp == `ECF_GRP_ENGAGE && wax == 3'(a)) begin
                    axis_reg[a] <= ECF_AX_WAIT;
                end
                if (reg_write && grp == `ECF_GRP_DISENGAGE && wax == 3'(a)) begin
                    disarm_reg[a] <= 1'b1;
                end
            end
        end
    end

    // targets refreshed one axis per cycle
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rr_reg <= 3'h0;
            for (int a = 0; a < `ECF_AXES; a++) begin
                target_reg[a] <= 32'h0;
            end
        end else begin
            rr_reg <= rr_reg + 3'h1;
            target_reg[rr_reg] <= t_wrap;
        end
    end

    // ======================================================================
    // outputs
    always_comb begin
        for (int a = 0; a < `ECF_AXES; a++) begin
            slave_target[32*a +: 32] = target_reg[a];
            slave_following[a] = (axis_reg[a] == ECF_AX_FOLLOW);
        end
    end
    assign slave_redefine = redef_reg;
    assign master_redefine = wrap_reg;

    // read data stand only in the cycle after the strobe; unmapped reads zero
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            reg_rdata <= 32'h0;
        end else if (!reg_read) begin
            reg_rdata <= 32'h0;
        end else begin
            unique case (grp)
                3'h0: begin
                    unique case (reg_addr)
                        `ECF_OFS_ENABLE: reg_rdata <= {31'h0, cam_on};
                        `ECF_OFS_MASTER: reg_rdata <= {29'h0, master_reg};
                        `ECF_OFS_CYCLE: reg_rdata <= cycle_reg;
                        `ECF_OFS_WIDTH: reg_rdata <= width_reg;
                        `ECF_OFS_START: reg_rdata <= start_reg;
                        `ECF_OFS_INDEX: reg_rdata <= {23'h0, index_reg};
                        `ECF_OFS_MPOS: reg_rdata <= mpos_reg;
                        `ECF_OFS_TPTR: reg_rdata <= {23'h0, tptr_reg};
                        default: reg_rdata <= 32'h0;
                    endcase
                end
                `ECF_GRP_CHANGE: reg_rdata <= change_reg[wax];
                `ECF_GRP_ENGAGE: reg_rdata <= engage_reg[wax];
                `ECF_GRP_DISENGAGE: reg_rdata <= disengage_reg[wax];
                `ECF_GRP_TARGET: reg_rdata <= target_reg[wax];
                `ECF_GRP_STATUS: reg_rdata <= {29'h0, disarm_reg[wax], axis_reg[wax]};
                default: reg_rdata <= 32'h0;
            endcase
        end
    end

    // ======================================================================
    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_mpos_in_cycle: assert property (cam_on && $past(cam_on) && cycle_reg != 0 &&
        $stable(cycle_reg) && $past(wrap_reg) |-> mpos_reg < cycle_reg)
        else $error("wrapped master outside cycle");
    a_wrap_redefine: assert property (cam_on && slave_following[0] && !$past(wrap_reg) &&
        wrap_reg && !reg_write |=> slave_redefine[0] || !slave_following[0])
        else $error("cycle end did not redefine follower");
    a_cycle_limit: assert property (cycle_reg <= `ECF_CYCLE_MAX)
        else $error("cycle above limit");
    a_enable_write: assert property (reg_write && reg_addr == `ECF_OFS_ENABLE |=>
        cam_on == $past(reg_wdata[0]))
        else $error("enable write not obeyed");
    a_master_idle: assert property (##1 slave_following[master_reg] |->
        $past(master_reg) != master_reg)
        else $error("master axis is following");
    a_engage_match: assert property (axis_reg[1] == ECF_AX_WAIT && cam_on && master_reg != 3'h1
        && mpos_reg == engage_reg[1] && !reg_write |=> slave_following[1] && slave_redefine[1])
        else $error("engage point missed");
    a_engage_far: assert property (axis_reg[2] == ECF_AX_WAIT && cam_on && master_reg != 3'h2
        && engage_reg[2] >= cycle_reg && !reg_write |=> slave_following[2])
        else $error("out of range engage not immediate");
    a_disengage: assert property (slave_following[1] && disarm_reg[1] &&
        mpos_reg == disengage_reg[1] && !reg_write |=> !slave_following[1])
        else $error("disengage point missed");
    a_enable_read: assert property (reg_read && reg_addr == `ECF_OFS_ENABLE |=>
        reg_rdata == {31'h0, $past(cam_on)} ##1 reg_rdata == 32'h0 || $past(reg_read))
        else $error("enable state read wrong");
    a_index_write: assert property (reg_write && reg_addr == `ECF_OFS_INDEX &&
        reg_wdata < 32'h100 |=> index_reg == $past(reg_wdata[8:0]))
        else $error("index write lost");

    c_engage: cover property (axis_reg[1] == ECF_AX_WAIT ##1 slave_following[1]);
    c_wrap: cover property (cam_on && master_redefine);
    c_disengage: cover property (slave_following[1] ##1 !slave_following[1]);

endmodule : ecf_cam_follower

`default_nettype wire

/* ecf_far_side.sv */
/*
 * far side of the cam follower: the main encoder counters and a helper of
 * the host command interpreter.
 * assumes the bench raises step for every count the master should move.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ecf_params.svh"

module ecf_far_side
    import ecf_pkg::*;
#(
    parameter logic [31:0] START_COUNT = 32'h00001000
)
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // motion request
    input wire logic [2:0] master_axis,
    input wire logic step,
    // main encoder counts
    output logic [`ECF_AXES*32-1:0] enc_pos
);
    // ======================================================================
    // counters
    logic [31:0] count_reg [`ECF_AXES];

    // only the master moves; others sit at distinct counts to catch a wrong pick
    always_ff @(posedge clock) begin
        for (int a = 0; a < `ECF_AXES; a++) begin
            if (!rst_n) begin
                count_reg[a] <= START_COUNT + 32'(a * 'h111);
            end else if (step && master_axis == 3'(a)) begin
                count_reg[a] <= count_reg[a] + 32'h00000001;
            end
        end
    end

    // counts leave on the main encoder lines only, never an auxiliary path
    always_comb begin
        for (int a = 0; a < `ECF_AXES; a++) begin
            enc_pos[a*32 +: 32] = count_reg[a];
        end
    end

    // a falling slave is commanded by its magnitude
    function automatic logic [31:0] magnitude(input logic signed [31:0] v);
        return (v < 0) ? 32'(-v) : 32'(v);
    endfunction : magnitude

endmodule : ecf_far_side
`default_nettype wire

/* tb.sv */
/*
 * self-checking bench of the cam follower.
 * assumes ecf_params.svh is on the include path and one 40 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ecf_params.svh"

module tb;
    // ======================================================================
    // signals
    typedef struct packed {logic [7:0] a; logic [31:0] w; logic [31:0] e;} ecf_row_type;
    localparam ecf_row_type ROWS [10] = '{
        '{8'h08, 32'hffffffff, 32'h007fffff}, '{8'h20, 32'h80000005, 32'h7fffffff},
        '{8'h14, 32'h0000012c, 32'h000000ff}, '{8'h14, 32'h00000007, 32'h00000007},
        '{8'he0, 32'h00000005, 32'h00000000}, '{8'h84, 32'h00000005, 32'h00000000},
        '{8'h04, 32'h0000000b, 32'h00000003}, '{8'h08, 32'h00000064, 32'h00000064},
        '{8'h0c, 32'h00000019, 32'h00000019}, '{8'h10, 32'h00000000, 32'h00000000}};
    localparam logic [31:0] PTS [5] = '{32'h0, 32'h64, 32'h28, 32'h12c, 32'h0};
    logic clock, rst_n, reg_write, reg_read, master_redefine, step;
    logic [7:0] reg_addr, slave_following, slave_redefine;
    logic [31:0] reg_wdata, reg_rdata, v;
    logic [255:0] main_enc_pos, slave_target;
    int mismatches, total_checks, wraps, engages, pos;

    ecf_cam_follower i_ecf_cam_follower (.clock(clock), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .main_enc_pos(main_enc_pos),
        .slave_target(slave_target), .slave_following(slave_following),
        .slave_redefine(slave_redefine), .master_redefine(master_redefine));
    ecf_far_side i_ecf_far_side (.clock(clock), .rst_n(rst_n), .master_axis(3'h3),
        .step(step), .enc_pos(main_enc_pos));

    // ======================================================================
    // helpers
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // bus cycles leave a gap so a strobe is never raised and lowered at one edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd

    task automatic advance(input int n);
        @(posedge clock);
        step <= 1'b1;
        repeat (n) @(posedge clock);
        step <= 1'b0;
        pos += n;
        repeat (10) @(posedge clock);
    endtask : advance

    task automatic want_follow(input logic [7:0] exp);
        int n;
        n = 0;
        while (slave_following !== exp && n < 20) begin
            @(posedge clock);
            n++;
        end
        chk("following", {24'h0, slave_following}, {24'h0, exp});
        if (slave_following !== exp) final_report();
    endtask : want_follow

    // truncating interpolation over a width of 25
    function automatic logic [31:0] interp(input int m);
        int k;
        k = m / 25;
        return 32'(int'(PTS[k]) + (int'(PTS[k+1]) - int'(PTS[k])) * (m % 25) / 25);
    endfunction : interp

    task automatic final_report;
        if (mismatches == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : final_report

    // ======================================================================
    // clock, pulse counters and watchdog
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    always @(posedge clock) begin
        if (rst_n === 1'b1 && master_redefine === 1'b1) wraps++;
        if (rst_n === 1'b1 && slave_redefine[1] === 1'b1) engages++;
    end

    initial begin
        repeat (20000) @(posedge clock);
        mismatches++;
        final_report();
    end

    // ======================================================================
    // main sequence
    initial begin
        rst_n = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_write = 1'b0;
        reg_read = 1'b0;
        step = 1'b0;
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        rd(`ECF_OFS_ENABLE, v);
        chk("enable at reset", v, 32'h0);
        rd(`ECF_OFS_WIDTH, v);
        chk("width at reset", v, `ECF_RST_WIDTH);
        want_follow(8'h00);
        // register rows also leave cycle 100, width 25, start 0, master axis 3
        foreach (ROWS[k]) begin
            wr(ROWS[k].a, ROWS[k].w);
            rd(ROWS[k].a, v);
            chk("register", v, ROWS[k].e);
        end
        wr(8'h30, i_ecf_far_side.magnitude(-300));
        rd(8'h30, v);
        chk("change magnitude", v, 32'd300);
        for (int i = 0; i < 5; i++) begin
            wr(`ECF_OFS_TPTR, 32'(i));
            wr(8'h84, PTS[i]);
        end
        wr(`ECF_OFS_ENABLE, 32'h1);
        rd(`ECF_OFS_ENABLE, v);
        chk("enable on", v, 32'h1);
        wr(8'h44, 32'd10);
        rd(8'hc4, v);
        chk("axis waits", v, 32'h1);
        pos = 0;
        advance(9);
        chk("early engage", {31'h0, slave_following[1]}, 32'h0);
        advance(1);
        want_follow(8'h02);
        chk("engage pulse", 32'(engages), 32'h1);
        // probes cover a falling and a rising table segment
        for (int p = 10; p <= 60; p += 25) begin
            if (p > pos) advance(p - pos);
            rd(`ECF_OFS_MPOS, v);
            chk("master pos", v, 32'(p));
            rd(`ECF_OFS_INDEX, v);
            chk("index", v, 32'(p / 25));
            chk("target", slave_target[63:32], interp(p));
        end
        wr(8'h64, 32'd70);
        advance(9);
        chk("early release", {31'h0, slave_following[1]}, 32'h1);
        advance(1);
        want_follow(8'h00);
        advance(135);
        rd(`ECF_OFS_MPOS, v);
        chk("wrapped pos", v, 32'd5);
        chk("wraps", 32'(wraps), 32'h2);
        wr(8'h48, 32'd200);
        want_follow(8'h04);
        wr(8'h68, 32'd500);
        want_follow(8'h00);
        wr(`ECF_OFS_MASTER, 32'h5);
        rd(`ECF_OFS_MASTER, v);
        chk("master kept", v, 32'h3);
        for (int a = 0; a < 8; a++) begin
            wr(8'(8'h40 + 4 * a), 32'd200);
        end
        want_follow(8'hf7);
        // a wrap while following must redefine the followers too
        advance(100);
        chk("wraps again", 32'(wraps), 32'h3);
        chk("slave wrap pulse", 32'(engages), 32'h3);
        chk("following kept", {24'h0, slave_following}, 32'h000000f7);
        wr(`ECF_OFS_ENABLE, 32'h0);
        rd(`ECF_OFS_ENABLE, v);
        chk("enable off", v, 32'h0);
        want_follow(8'h00);
        // reset in mid-run must restore the configuration defaults
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        rd(`ECF_OFS_WIDTH, v);
        chk("width after reset", v, `ECF_RST_WIDTH);
        rd(`ECF_OFS_CYCLE, v);
        chk("cycle after reset", v, `ECF_RST_ZERO);
        rd(`ECF_OFS_MASTER, v);
        chk("master after reset", v, 32'h0);
        want_follow(8'h00);
        final_report();
    end

endmodule : tb
`default_nettype wire
